// ==== pdr_power_reset_ctrl.sv ====
// What this block does
// - The ADC is powered down whenever no pin is set up as an ADC input and no temperature read is active.
// - A temperature read powers the ADC up even when no pin is an ADC input.
// - Global shutdown at bit 10 powers down all DACs, the reference and the ADC.
// - While global shutdown is set the reference enable and channel sleep bits have no effect.
// - Reference enable at bit 9 powers the reference and buffer and drives the reference pin.
// - Each sleep bit 7..0 powers down its channel only if that channel is a DAC.
// - Writing 0x0DAC to the reset pointer 0x0F performs a full software reset.
// - A reset returns all registers and all pins to their defaults (weak pull-down).
// - The soft reset fires on the falling SCL edge of the last data bit and is not acknowledged.
// - A falling edge on the hardware reset pin starts the same reset sequence.
// - A reset completes within 100 us; meanwhile the link ignores SCL traffic and acknowledges nothing.
// - A powered-down DAC output is three-stated and resumes its old value on wake.
`timescale 1ns/1ns
module pdr_power_reset_ctrl
   import pdr_pkg::*;
#(
   parameter logic [6:0] I2C_ADDR     = I2C_ADDR_DEF,
   parameter int         RESET_CYCLES = RESET_CYCLES_DEF
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             link_clk,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe,
   input  wire logic             hw_reset_pin_n,
   input  wire logic [7:0]       dac_mode_mask,
   input  wire logic [7:0]       adc_mode_mask,
   input  wire logic             temp_read_active,
   output pdr_power_state_t      power_state,
   output logic                  defaults_reset
);

   // ==========================================================================
   // Helpers
   function automatic logic [15:0] pwr_word(input pdr_pwr_ctrl_t p);
      pwr_word = {5'h00, p.global_shutdown, p.ref_enable, 1'b0, p.dac_channel_sleep};
   endfunction

   function automatic pdr_pwr_ctrl_t pwr_unpack(input logic [15:0] w);
      pdr_pwr_ctrl_t p;
      p.global_shutdown   = w[GS_BIT];
      p.ref_enable        = w[REF_BIT];
      p.dac_channel_sleep = w[SLEEP_MSB:0];
      pwr_unpack = p;
   endfunction

   function automatic logic [7:0] rd_byte(input logic [2:0] idx, input logic [7:0] ptr,
                                          input pdr_pwr_ctrl_t p);
      logic [15:0] w;
      w = (ptr == PTR_POWER_CTRL) ? pwr_word(p) : 16'h0000;
      case (idx)
         3'h1:    rd_byte = w[15:8];
         3'h2:    rd_byte = w[7:0];
         default: rd_byte = 8'h00;
      endcase
   endfunction

   // ==========================================================================
   // Link domain: pin and reset-busy synchronisers
   logic       s_scl;
   logic       s_sda;
   logic       s_busy;
   logic       busy_ff;

   pdr_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_scl (
      .clk    (link_clk),
      .resetn (resetn),
      .d      (scl_in),
      .q      (s_scl)
   );

   pdr_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_sda (
      .clk    (link_clk),
      .resetn (resetn),
      .d      (sda_in),
      .q      (s_sda)
   );

   pdr_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_busy (
      .clk    (link_clk),
      .resetn (resetn),
      .d      (busy_ff),
      .q      (s_busy)
   );

   // ==========================================================================
   // Link domain: I2C slave
   pdr_link_state_t state_ff, nxt_state;
   logic            scl_d_ff, nxt_scl_d;
   logic            sda_d_ff, nxt_sda_d;
   logic [3:0]      bit_cnt_ff, nxt_bit_cnt;
   logic [7:0]      shift_ff, nxt_shift;
   logic [7:0]      tx_ff, nxt_tx;
   logic [2:0]      byte_idx_ff, nxt_byte_idx;
   logic [7:0]      ptr_ff, nxt_ptr;
   logic [7:0]      msb_ff, nxt_msb;
   logic            rd_ff, nxt_rd;
   logic            oe_ff, nxt_oe;
   logic            out_ff, nxt_out;
   pdr_pwr_ctrl_t   pwr_ff, nxt_pwr;
   logic            wr_tgl_ff, nxt_wr_tgl;
   logic            srst_tgl_ff, nxt_srst_tgl;

   logic            scl_rise;
   logic            scl_fall;
   logic            start_cond;
   logic            stop_cond;
   logic [15:0]     data_word;

   assign scl_rise   = s_scl & ~scl_d_ff;
   assign scl_fall   = ~s_scl & scl_d_ff;
   assign start_cond = s_scl & scl_d_ff & sda_d_ff & ~s_sda;
   assign stop_cond  = s_scl & scl_d_ff & ~sda_d_ff & s_sda;
   assign data_word  = {msb_ff, shift_ff};

   always_comb
   begin
      nxt_state    = state_ff;
      nxt_scl_d    = s_scl;
      nxt_sda_d    = s_sda;
      nxt_bit_cnt  = bit_cnt_ff;
      nxt_shift    = shift_ff;
      nxt_tx       = tx_ff;
      nxt_byte_idx = byte_idx_ff;
      nxt_ptr      = ptr_ff;
      nxt_msb      = msb_ff;
      nxt_rd       = rd_ff;
      nxt_oe       = oe_ff;
      nxt_out      = 1'b0;
      nxt_pwr      = pwr_ff;
      nxt_wr_tgl   = wr_tgl_ff;
      nxt_srst_tgl = srst_tgl_ff;
      if (s_busy)
      begin
         nxt_state = L_IDLE;
         nxt_oe    = 1'b0;
         nxt_pwr   = pwr_unpack(PWR_CTRL_RESET);
         nxt_ptr   = 8'h00;
      end
      else if (stop_cond)
      begin
         nxt_state = L_IDLE;
         nxt_oe    = 1'b0;
      end
      else if (start_cond)
      begin
         nxt_state    = L_RX;
         nxt_bit_cnt  = 4'h0;
         nxt_byte_idx = 3'h0;
         nxt_oe       = 1'b0;
      end
      else
      begin
         case (state_ff)
            L_IDLE:
            begin
               nxt_oe = 1'b0;
            end
            L_RX:
            begin
               if (scl_rise)
               begin
                  nxt_shift   = {shift_ff[6:0], s_sda};
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
               end
               else if (scl_fall && bit_cnt_ff == 4'h8)
               begin
                  nxt_bit_cnt = 4'h0;
                  nxt_state   = L_ACK;
                  nxt_oe      = 1'b1;
                  if (byte_idx_ff != 3'h7)
                  begin
                     nxt_byte_idx = byte_idx_ff + 3'h1;
                  end
                  case (byte_idx_ff)
                     3'h0:
                     begin
                        nxt_rd = shift_ff[0];
                        nxt_tx = rd_byte(3'h1, ptr_ff, pwr_ff);
                        if (shift_ff[7:1] != I2C_ADDR)
                        begin
                           nxt_state = L_WAIT;
                           nxt_oe    = 1'b0;
                        end
                     end
                     3'h1:
                     begin
                        nxt_ptr = shift_ff;
                     end
                     3'h2:
                     begin
                        nxt_msb = shift_ff;
                     end
                     3'h3:
                     begin
                        if (ptr_ff == PTR_SOFT_RESET && data_word == SOFT_RESET_MAGIC)
                        begin
                           nxt_srst_tgl = ~srst_tgl_ff;
                           nxt_state    = L_WAIT;
                           nxt_oe       = 1'b0;
                        end
                        else if (ptr_ff == PTR_POWER_CTRL)
                        begin
                           nxt_pwr    = pwr_unpack(data_word);
                           nxt_wr_tgl = ~wr_tgl_ff;
                        end
                     end
                     default:
                     begin
                        nxt_oe = 1'b1;
                     end
                  endcase
               end
            end
            L_ACK:
            begin
               if (scl_fall)
               begin
                  nxt_bit_cnt = 4'h0;
                  if (rd_ff)
                  begin
                     nxt_state = L_TX;
                     nxt_oe    = ~tx_ff[7];
                  end
                  else
                  begin
                     nxt_state = L_RX;
                     nxt_oe    = 1'b0;
                  end
               end
            end
            L_TX:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt_ff == 4'h7)
                  begin
                     nxt_state = L_RACK;
                     nxt_oe    = 1'b0;
                  end
                  else
                  begin
                     nxt_bit_cnt = bit_cnt_ff + 4'h1;
                     nxt_tx      = {tx_ff[6:0], 1'b0};
                     nxt_oe      = ~tx_ff[6];
                  end
               end
            end
            L_RACK:
            begin
               if (scl_rise)
               begin
                  if (s_sda)
                  begin
                     nxt_state = L_WAIT;
                  end
                  else
                  begin
                     nxt_tx = rd_byte(byte_idx_ff + 3'h1, ptr_ff, pwr_ff);
                     if (byte_idx_ff != 3'h7)
                     begin
                        nxt_byte_idx = byte_idx_ff + 3'h1;
                     end
                  end
               end
               else if (scl_fall)
               begin
                  nxt_state   = L_TX;
                  nxt_bit_cnt = 4'h0;
                  nxt_oe      = ~tx_ff[7];
               end
            end
            L_WAIT:
            begin
               nxt_oe = 1'b0;
            end
            default:
            begin
               nxt_state = L_IDLE;
               nxt_oe    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff    <= L_IDLE;
         scl_d_ff    <= 1'b1;
         sda_d_ff    <= 1'b1;
         bit_cnt_ff  <= 4'h0;
         shift_ff    <= 8'h00;
         tx_ff       <= 8'h00;
         byte_idx_ff <= 3'h0;
         ptr_ff      <= 8'h00;
         msb_ff      <= 8'h00;
         rd_ff       <= 1'b0;
         oe_ff       <= 1'b0;
         out_ff      <= 1'b0;
         pwr_ff      <= {PWR_CTRL_RESET[GS_BIT], PWR_CTRL_RESET[REF_BIT],
                         PWR_CTRL_RESET[SLEEP_MSB:0]};
         wr_tgl_ff   <= 1'b0;
         srst_tgl_ff <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         scl_d_ff    <= nxt_scl_d;
         sda_d_ff    <= nxt_sda_d;
         bit_cnt_ff  <= nxt_bit_cnt;
         shift_ff    <= nxt_shift;
         tx_ff       <= nxt_tx;
         byte_idx_ff <= nxt_byte_idx;
         ptr_ff      <= nxt_ptr;
         msb_ff      <= nxt_msb;
         rd_ff       <= nxt_rd;
         oe_ff       <= nxt_oe;
         out_ff      <= nxt_out;
         pwr_ff      <= nxt_pwr;
         wr_tgl_ff   <= nxt_wr_tgl;
         srst_tgl_ff <= nxt_srst_tgl;
      end
   end

   assign sda_out = out_ff;
   assign sda_oe  = oe_ff;

   // ==========================================================================
   // Core domain: crossings from the link and the reset pin
   logic [2:0] s_core;
   logic       pin_d_ff, nxt_pin_d;
   logic       wr_d_ff, nxt_wr_d;
   logic       srst_d_ff, nxt_srst_d;

   pdr_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_pin (
      .clk    (clk),
      .resetn (resetn),
      .d      (hw_reset_pin_n),
      .q      (s_core[2])
   );

   pdr_sync2 #(.WIDTH(2), .RST_VAL(1'b0)) u_sync_tgl (
      .clk    (clk),
      .resetn (resetn),
      .d      ({wr_tgl_ff, srst_tgl_ff}),
      .q      (s_core[1:0])
   );

   // ==========================================================================
   // Core domain: reset sequencer and power state
   logic [RST_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic                 nxt_busy;
   pdr_pwr_ctrl_t        pwr_core_ff, nxt_pwr_core;
   pdr_power_state_t     state_out_ff, nxt_state_out;
   logic                 hw_fall;
   logic                 sw_req;
   logic                 wr_evt;
   logic                 gs;

   // Reset pin is expected high in normal use; only its falling edge counts
   assign hw_fall = pin_d_ff & ~s_core[2];
   assign sw_req  = s_core[0] ^ srst_d_ff;
   assign wr_evt  = s_core[1] ^ wr_d_ff;
   assign gs      = pwr_core_ff.global_shutdown;

   always_comb
   begin
      nxt_pin_d    = s_core[2];
      nxt_wr_d     = s_core[1];
      nxt_srst_d   = s_core[0];
      nxt_busy     = busy_ff;
      nxt_cnt      = cnt_ff;
      nxt_pwr_core = pwr_core_ff;
      if (busy_ff)
      begin
         nxt_pwr_core = pwr_unpack(PWR_CTRL_RESET);
         if (cnt_ff == '0)
         begin
            nxt_busy = 1'b0;
         end
         else
         begin
            nxt_cnt = cnt_ff - 1'b1;
         end
      end
      else if (hw_fall || sw_req)
      begin
         nxt_busy     = 1'b1;
         nxt_cnt      = RST_CNT_W'(RESET_CYCLES - 1);
         nxt_pwr_core = pwr_unpack(PWR_CTRL_RESET);
      end
      else if (wr_evt)
      begin
         // Link holds the word steady long after its toggle
         nxt_pwr_core = pwr_ff;
      end
      nxt_state_out.dac_powered_down = dac_mode_mask &
         (gs ? 8'hFF : pwr_core_ff.dac_channel_sleep);
      nxt_state_out.ref_powered_up   = ~gs & pwr_core_ff.ref_enable;
      nxt_state_out.adc_powered_up   = ~gs & ~busy_ff &
         ((|adc_mode_mask) | temp_read_active);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_d_ff     <= 1'b1;
         wr_d_ff      <= 1'b0;
         srst_d_ff    <= 1'b0;
         busy_ff      <= 1'b0;
         cnt_ff       <= '0;
         pwr_core_ff  <= {PWR_CTRL_RESET[GS_BIT], PWR_CTRL_RESET[REF_BIT],
                          PWR_CTRL_RESET[SLEEP_MSB:0]};
         state_out_ff <= '0;
      end
      else
      begin
         pin_d_ff     <= nxt_pin_d;
         wr_d_ff      <= nxt_wr_d;
         srst_d_ff    <= nxt_srst_d;
         busy_ff      <= nxt_busy;
         cnt_ff       <= nxt_cnt;
         pwr_core_ff  <= nxt_pwr_core;
         state_out_ff <= nxt_state_out;
      end
   end

   assign power_state    = state_out_ff;
   assign defaults_reset = busy_ff;

endmodule

// ==== pdr_pkg.sv ====
package pdr_pkg;

   // ==========================================================================
   // Pointer bytes and command values
   localparam logic [7:0]  PTR_POWER_CTRL   = 8'h0B;
   localparam logic [7:0]  PTR_SOFT_RESET   = 8'h0F;
   localparam logic [15:0] SOFT_RESET_MAGIC = 16'h0DAC;
   localparam logic [6:0]  I2C_ADDR_DEF     = 7'h10;

   // ==========================================================================
   // Power and reference control field layout
   localparam int          GS_BIT           = 10;
   localparam int          REF_BIT          = 9;
   localparam int          SLEEP_MSB        = 7;
   localparam logic [15:0] PWR_CTRL_RESET   = 16'h0000;

   // ==========================================================================
   // Timing
   localparam int          CLK_MHZ          = 125;
   localparam int          RESET_TIME_US    = 100;
   localparam int          RESET_CYCLES_DEF = RESET_TIME_US * CLK_MHZ;
   localparam int          RST_CNT_W        = 14;

   // ==========================================================================
   // Types
   typedef struct packed {
      logic       global_shutdown;
      logic       ref_enable;
      logic [7:0] dac_channel_sleep;
   } pdr_pwr_ctrl_t;

   typedef struct packed {
      logic [7:0] dac_powered_down;
      logic       ref_powered_up;
      logic       adc_powered_up;
   } pdr_power_state_t;

   typedef enum logic [5:0] {
      L_IDLE = 6'h01,
      L_RX   = 6'h02,
      L_ACK  = 6'h04,
      L_TX   = 6'h08,
      L_RACK = 6'h10,
      L_WAIT = 6'h20
   } pdr_link_state_t;

endpackage

// ==== pdr_sync2.sv ====
`timescale 1ns/1ns
module pdr_sync2 #(
   parameter int         WIDTH   = 1,
   parameter logic [0:0] RST_VAL = 1'b0
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   // ==========================================================================
   // Two-stage synchroniser
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_ff <= {WIDTH{RST_VAL}};
         q_ff    <= {WIDTH{RST_VAL}};
      end
      else
      begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule

// ==== pdr_power_reset_ctrl_monitor.sv ====
`timescale 1ns/1ns
module pdr_power_reset_ctrl_monitor
   import pdr_pkg::*;
#(
   parameter int RESET_CYCLES = RESET_CYCLES_DEF
) (
   input wire logic             clk,
   input wire logic             resetn,
   input wire logic             link_clk,
   input wire logic             scl_in,
   input wire logic             sda_in,
   input wire logic             sda_out,
   input wire logic             sda_oe,
   input wire logic             hw_reset_pin_n,
   input wire logic [7:0]       dac_mode_mask,
   input wire logic [7:0]       adc_mode_mask,
   input wire logic             temp_read_active,
   input wire pdr_power_state_t power_state,
   input wire logic             defaults_reset
);
   // ==========================================================================
   // Length of the current reset pulse
   logic [15:0] busy_cnt_ff;
   logic [15:0] nxt_busy_cnt;

   always_comb nxt_busy_cnt = defaults_reset ? busy_cnt_ff + 16'h0001 : 16'h0000;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn) busy_cnt_ff <= 16'h0000;
      else busy_cnt_ff <= nxt_busy_cnt;
   end

   // ==========================================================================
   // Properties
   property p_adc_needs_src;
      @(posedge clk) disable iff (!resetn)
      power_state.adc_powered_up |-> $past(|adc_mode_mask || temp_read_active);
   endproperty
   a_adc_needs_src: assert property (p_adc_needs_src)
      else $error("adc up without any source");

   property p_adc_follows;
      @(posedge clk) disable iff (!resetn)
      power_state.ref_powered_up && !$past(defaults_reset) |->
         power_state.adc_powered_up == $past(|adc_mode_mask || temp_read_active);
   endproperty
   a_adc_follows: assert property (p_adc_follows)
      else $error("adc state does not follow its sources");

   property p_dac_only_if_dac;
      @(posedge clk) disable iff (!resetn)
      (power_state.dac_powered_down & ~$past(dac_mode_mask)) == 8'h00;
   endproperty
   a_dac_only_if_dac: assert property (p_dac_only_if_dac)
      else $error("non dac channel powered down");

   property p_reset_holds_off;
      @(posedge clk) disable iff (!resetn)
      busy_cnt_ff > 16'h0020 |-> !power_state.adc_powered_up && !power_state.ref_powered_up;
   endproperty
   a_reset_holds_off: assert property (p_reset_holds_off)
      else $error("adc or reference up during reset");

   property p_reset_clears;
      @(posedge clk) disable iff (!resetn)
      $fell(defaults_reset) |->
         power_state.dac_powered_down == 8'h00 && !power_state.ref_powered_up;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("power control not cleared by reset");

   property p_hw_edge;
      @(posedge clk) disable iff (!resetn)
      $fell(hw_reset_pin_n) && !defaults_reset |-> ##[1:6] defaults_reset;
   endproperty
   a_hw_edge: assert property (p_hw_edge)
      else $error("reset pin edge did not start reset");

   property p_reset_len;
      @(posedge clk) disable iff (!resetn)
      $fell(defaults_reset) |-> busy_cnt_ff == 16'(RESET_CYCLES);
   endproperty
   a_reset_len: assert property (p_reset_len)
      else $error("reset pulse length wrong");

   property p_no_ack_busy;
      @(posedge link_clk) disable iff (!resetn)
      defaults_reset [*6] |-> !sda_oe;
   endproperty
   a_no_ack_busy: assert property (p_no_ack_busy)
      else $error("data line driven during reset");
endmodule

// ==== pdr_i2c_host.sv ====
`timescale 1ns/1ns
module pdr_i2c_host
   import pdr_pkg::*;
(
   output logic      scl,
   output logic      sda,
   input  wire logic sda_oe,
   input  wire logic sda_out
);
   localparam int Q = 100;
   logic sda_low;

   // Open-drain wire with pull-up: released line reads high
   assign sda = !(sda_low || (sda_oe && !sda_out));

   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic start_c;
      sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
   endtask

   task automatic stop_c;
      sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask

   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= -1; i--)
      begin
         sda_low = (i < 0) ? mack : !d[i];
         #Q scl = 1'b1;
         #Q;
         if (i >= 0) q[i] = sda;
         else ack = !sda;
         #Q scl = 1'b0;
         #Q;
      end
   endtask

   task automatic wr(input logic [7:0] ptr, input logic [15:0] w, output logic [3:0] a);
      logic [7:0] q;
      start_c();
      xfer({I2C_ADDR_DEF, 1'b0}, 1'b0, q, a[3]);
      xfer(ptr, 1'b0, q, a[2]);
      xfer(w[15:8], 1'b0, q, a[1]);
      xfer(w[7:0], 1'b0, q, a[0]);
      stop_c();
   endtask

   task automatic rd(output logic [15:0] w, output logic a);
      logic [7:0] q;
      logic n;
      start_c();
      xfer({I2C_ADDR_DEF, 1'b1}, 1'b0, q, a);
      xfer(8'hFF, 1'b1, w[15:8], n);
      xfer(8'hFF, 1'b0, w[7:0], n);
      stop_c();
   endtask

   task automatic probe(output logic a);
      logic [7:0] q;
      start_c();
      xfer({I2C_ADDR_DEF, 1'b0}, 1'b0, q, a);
      stop_c();
   endtask
endmodule

// ==== pdr_power_reset_ctrl_tb_top.sv ====
`timescale 1ns/1ns
module pdr_power_reset_ctrl_tb_top
   import pdr_pkg::*;
();
   localparam int    RST_CYC = 1000;
   logic             clk;
   logic             link_clk;
   logic             resetn;
   logic             scl;
   logic             sda;
   logic             sda_out;
   logic             sda_oe;
   logic             hw_reset_pin_n;
   logic [7:0]       dac_mode_mask;
   logic [7:0]       adc_mode_mask;
   logic             temp_read_active;
   pdr_power_state_t power_state;
   logic             defaults_reset;
   int               failures;
   int               n_checks;
   pdr_power_state_t ps_q[$];
   event             ps_ev;

   initial clk = 1'b0;
   initial link_clk = 1'b0;
   always #4 clk = ~clk;
   always #6 link_clk = ~link_clk;

   pdr_power_reset_ctrl #(.RESET_CYCLES(RST_CYC)) pdr_power_reset_ctrl_i (
      .clk(clk), .resetn(resetn), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .hw_reset_pin_n(hw_reset_pin_n),
      .dac_mode_mask(dac_mode_mask), .adc_mode_mask(adc_mode_mask),
      .temp_read_active(temp_read_active), .power_state(power_state),
      .defaults_reset(defaults_reset));

   pdr_i2c_host pdr_i2c_host_i (.scl(scl), .sda(sda), .sda_oe(sda_oe), .sda_out(sda_out));

   // ==========================================================================
   // Checking
   task automatic chk_ps(input pdr_power_state_t e);
      n_checks++;
      if (power_state !== e)
      begin
         failures++;
         $display("[FAIL] power_state exp %h got %h", e, power_state);
      end
   endtask

   task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask

   always @(ps_ev) chk_ps(ps_q.pop_front());

   // Notes the expected power state, then lets the watcher compare it
   task automatic put(input logic [15:0] r);
      pdr_power_state_t e;
      e.dac_powered_down = dac_mode_mask & (r[GS_BIT] ? 8'hFF : r[SLEEP_MSB:0]);
      e.ref_powered_up = !r[GS_BIT] && r[REF_BIT];
      e.adc_powered_up = !r[GS_BIT] && (|adc_mode_mask || temp_read_active);
      ps_q.push_back(e);
      repeat (12) @(negedge clk);
      ->ps_ev;
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 4000 && defaults_reset !== 1'b0; i++) @(negedge clk);
      chk_w("busy_end", 16'h0000, {15'h0000, defaults_reset});
   endtask

   task automatic final_report;
      if (failures == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      #700000;
      failures++;
      final_report();
   end

   // ==========================================================================
   // Scenarios
   initial
   begin
      logic [3:0]  a;
      logic [15:0] w;
      logic [15:0] v;
      logic        r;
      resetn = 1'b0;
      hw_reset_pin_n = 1'b1;
      dac_mode_mask = 8'h00;
      adc_mode_mask = 8'h00;
      temp_read_active = 1'b0;
      failures = 0;
      n_checks = 0;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      v = 16'($urandom(83));
      repeat (8) @(negedge clk);
      put(16'h0000);
      temp_read_active = 1'b1;
      put(16'h0000);
      temp_read_active = 1'b0;
      adc_mode_mask = 8'($urandom_range(255, 1));
      put(16'h0000);
      adc_mode_mask = 8'h00;
      put(16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         @(negedge clk);
         dac_mode_mask = 8'($urandom);
         adc_mode_mask = i[0] ? 8'h00 : 8'($urandom);
         temp_read_active = i[1];
         v = 16'($urandom) & 16'h06FF;
         v[GS_BIT] = (i >= 4);
         v[REF_BIT] = (i != 3);
         pdr_i2c_host_i.wr(PTR_POWER_CTRL, v, a);
         chk_w("ack", 16'h000F, {12'h000, a});
         put(v);
         pdr_i2c_host_i.rd(w, r);
         chk_w("rd_ack", 16'h0001, {15'h0000, r});
         chk_w("readback", v, w);
      end
      @(negedge clk);
      dac_mode_mask = 8'hFF;
      adc_mode_mask = 8'hFF;
      pdr_i2c_host_i.wr(PTR_SOFT_RESET, SOFT_RESET_MAGIC, a);
      chk_w("reset_ack", 16'h000E, {12'h000, a});
      pdr_i2c_host_i.probe(r);
      chk_w("busy_ack", 16'h0000, {15'h0000, r});
      wait_idle();
      put(16'h0000);
      pdr_i2c_host_i.probe(r);
      chk_w("idle_ack", 16'h0001, {15'h0000, r});
      v = 16'h02A5;
      pdr_i2c_host_i.wr(PTR_POWER_CTRL, v, a);
      chk_w("ack2", 16'h000F, {12'h000, a});
      put(v);
      hw_reset_pin_n = 1'b0;
      repeat (6) @(negedge clk);
      chk_w("hw_busy", 16'h0001, {15'h0000, defaults_reset});
      hw_reset_pin_n = 1'b1;
      wait_idle();
      put(16'h0000);
      pdr_i2c_host_i.rd(w, r);
      chk_w("rd_ack2", 16'h0001, {15'h0000, r});
      chk_w("reset_value", PWR_CTRL_RESET, w);
      final_report();
   end
endmodule

bind pdr_power_reset_ctrl pdr_power_reset_ctrl_monitor #(.RESET_CYCLES(RESET_CYCLES))
   pdr_power_reset_ctrl_monitor_i (
   .clk(clk), .resetn(resetn), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .hw_reset_pin_n(hw_reset_pin_n),
   .dac_mode_mask(dac_mode_mask), .adc_mode_mask(adc_mode_mask),
   .temp_read_active(temp_read_active), .power_state(power_state),
   .defaults_reset(defaults_reset));
